//--- logic/spi_shift_pkg.sv
// Shared constants, register map and carrier types of the serial shift port.
// Assumes a 32-bit APB master on the system clock and one external serial partner.
package spi_shift_pkg;

	// ============================================================
	// Widths
	localparam int ADDR_W  = 12;
	localparam int DATA_W  = 8;
	localparam int BAUD_W  = 16;
	localparam int CNT_W   = 4;
	localparam int LEN_W   = 3;
	localparam int SYNC_W  = 4;

	// ============================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_DATA    = 12'hF60;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 12'hF64;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'hF68;
	localparam logic [ADDR_W-1:0] OFS_MASK    = 12'hF6C;
	localparam logic [ADDR_W-1:0] OFS_BAUD_HI = 12'hF70;
	localparam logic [ADDR_W-1:0] OFS_BAUD_LO = 12'hF74;

	// ============================================================
	// Field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_MASTER_BIT = 1;
	localparam int CTRL_LEN_LSB    = 2;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_DONE_BIT     = 1;
	localparam int ST_COLL_BIT     = 2;
	localparam int ST_RXFULL_BIT   = 3;
	localparam int BYTE_HI_LSB     = 8;

	// ============================================================
	// Reset values and fixed counts
	localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] BAUD_HI_RST  = 8'hFF;
	localparam logic [DATA_W-1:0] BAUD_LO_RST  = 8'hFF;
	localparam logic [BAUD_W-1:0] BAUD_MIN     = 16'h0001;
	localparam logic [CNT_W-1:0]  FULL_LEN     = 4'h8;
	localparam logic [CNT_W-1:0]  CNT_ONE      = 4'h1;
	localparam logic [CNT_W-1:0]  CNT_ZERO     = 4'h0;
	localparam logic [LEN_W-1:0]  LEN_FULL_CODE = 3'h0;

	// ============================================================
	// Carrier types
	typedef struct packed {
		logic [LEN_W-1:0] char_length_field;
		logic             master;
		logic             enable;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{char_length_field: 3'h0, master: 1'b0, enable: 1'b0};

	typedef struct packed {
		logic collision;
		logic done;
	} events_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} pins_in_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
		logic ss_n;
		logic ss_n_oe;
	} pins_out_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SHIFT  = 2'b01,
		ST_FINISH = 2'b11
	} xfer_state_t;

endpackage

//--- logic/spi_pin_sync.sv
// Two-flop synchroniser for the serial pin inputs.
// Assumes inputs arrive asynchronously to clock; only stage two is read outside.
`timescale 1ns/1ps
module spi_pin_sync
	import spi_shift_pkg::*;
#(
	parameter int WIDTH = SYNC_W
)
(
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			meta_reg   <= '1;
			stable_reg <= '1;
		end
		else
		begin
			meta_reg   <= din;
			stable_reg <= meta_reg;
		end
	end

	assign dout = stable_reg;

endmodule

//--- logic/spi_baud_gen.sv
// Baud divider: one-cycle tick every reload system clocks while run is high.
// Assumes reload is static during a transfer; zero acts as one.
`timescale 1ns/1ps
module spi_baud_gen
	import spi_shift_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              run,
	input  wire logic [BAUD_W-1:0] reload,
	output logic                   tick
);

	logic [BAUD_W-1:0] cnt_reg;
	logic [BAUD_W-1:0] cnt_next;
	logic              tick_reg;
	logic              tick_next;
	logic [BAUD_W-1:0] reload_eff;

	always_comb
	begin
		reload_eff = (reload == '0) ? BAUD_MIN : reload;
		cnt_next   = cnt_reg;
		tick_next  = 1'b0;
		if (!run)
		begin
			cnt_next = reload_eff;
		end
		else if (cnt_reg <= BAUD_MIN)
		begin
			cnt_next  = reload_eff;
			tick_next = 1'b1;
		end
		else
		begin
			cnt_next = cnt_reg - BAUD_MIN;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cnt_reg  <= BAUD_MIN;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

//--- logic/spi_shift_port.sv
// Serial shift port: single 8-bit shift register, master or slave, APB registers.
// Assumes an APB master on clock; serial pins resolved by the surrounding pad logic.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module spi_shift_port
	import spi_shift_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire pins_in_t          pins_in,
	output pins_out_t              pins_out,
	output logic                   irq
);

	// ============================================================
	// Pin synchronisers and baud divider
	logic [SYNC_W-1:0] sync_out;
	pins_in_t          pin_s;
	logic              tick;
	logic              baud_run;

	spi_pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.din     (pins_in),
		.dout    (sync_out)
	);
	assign pin_s = pins_in_t'(sync_out);

	// ============================================================
	// State
	ctrl_t             ctrl_reg,    ctrl_next;
	logic [BAUD_W-1:0] baud_divisor_reg, baud_divisor_next;
	logic [DATA_W-1:0] serial_shift_data_reg, serial_shift_data_next;
	xfer_state_t       state_reg,   state_next;
	logic [CNT_W-1:0]  cnt_reg,     cnt_next;
	logic              sample_reg,  sample_next;
	logic              mck_reg,     mck_next;
	logic              sck_prev_reg;
	logic              rx_full_reg, rx_full_next;
	events_t           status_reg,  status_next;
	events_t           mask_reg,    mask_next;
	events_t           ev;
	pins_out_t         pins_reg,    pins_next;
	logic              irq_reg,     irq_next;
	logic [31:0]       prdata_reg,  prdata_next;
	logic              pready_reg,  pready_next;
	logic              pslverr_reg, pslverr_next;

	spi_baud_gen u_baud (
		.clock   (clock),
		.sys_rst (sys_rst),
		.run     (baud_run),
		.reload  (baud_divisor_reg),
		.tick    (tick)
	);

	// ============================================================
	// Bus decode
	logic        setup;
	logic        access;
	logic        wr_acc;
	logic        rd_acc;
	logic        wr_data;
	logic        wr_ok;
	logic        wr_coll;
	logic        slave_sel;
	logic        rise_ev;
	logic        fall_ev;
	logic        busy;
	logic [CNT_W-1:0] len_bits;

	assign setup   = psel & ~penable;
	assign access  = psel & penable & pready_reg;
	assign wr_acc  = access & pwrite;
	assign rd_acc  = access & ~pwrite;
	assign wr_data = wr_acc & (paddr == OFS_DATA);
	assign busy    = (state_reg != ST_IDLE);
	assign wr_coll = wr_data & (busy | rx_full_reg);
	assign wr_ok   = wr_data & ~wr_coll;

	// Master runs the divider only while shifting
	assign baud_run = ctrl_reg.enable & ctrl_reg.master & (state_reg == ST_SHIFT);

	// Select is low-true; edges seen only while selected
	assign slave_sel = ctrl_reg.enable & ~ctrl_reg.master & ~pin_s.ss_n;

	// Slave edges come from the synchronised clock; needs the slower partner clock
	always_comb
	begin
		rise_ev = 1'b0;
		fall_ev = 1'b0;
		if (ctrl_reg.master)
		begin
			rise_ev = baud_run & tick & ~mck_reg;
			fall_ev = baud_run & tick & mck_reg;
		end
		else if (slave_sel)
		begin
			rise_ev = pin_s.sck & ~sck_prev_reg;
			fall_ev = ~pin_s.sck & sck_prev_reg;
		end
	end

	// Length code zero means a full byte
	assign len_bits = (ctrl_reg.char_length_field == LEN_FULL_CODE) ?
		FULL_LEN : {1'b0, ctrl_reg.char_length_field};

	// ============================================================
	// Transfer engine
	always_comb
	begin
		state_next             = state_reg;
		cnt_next               = cnt_reg;
		sample_next            = sample_reg;
		mck_next               = mck_reg;
		serial_shift_data_next = serial_shift_data_reg;
		ev                     = '0;
		ev.collision           = wr_coll;
		case (state_reg)
			ST_IDLE:
			begin
				mck_next = 1'b0;
				cnt_next = CNT_ZERO;
				if (wr_ok)
				begin
					serial_shift_data_next = pwdata[DATA_W-1:0];
					if (ctrl_reg.enable && ctrl_reg.master)
					begin
						state_next = ST_SHIFT;
					end
				end
				else if (rise_ev && !ctrl_reg.master)
				begin
					sample_next = pin_s.mosi;
					state_next  = ST_SHIFT;
				end
			end
			ST_SHIFT:
			begin
				if (!ctrl_reg.enable || (!ctrl_reg.master && pin_s.ss_n))
				begin
					// Deselect or disable ends the transfer without done; the partial character stays in the shift register
					state_next = ST_IDLE;
				end
				else
				begin
					if (ctrl_reg.master && tick)
					begin
						mck_next = ~mck_reg;
					end
					if (rise_ev)
					begin
						sample_next = ctrl_reg.master ? pin_s.miso : pin_s.mosi;
					end
					if (fall_ev)
					begin
						// Out at bit 7, in at bit 0 in the same step
						serial_shift_data_next = {serial_shift_data_reg[DATA_W-2:0],
							sample_reg};
						cnt_next = cnt_reg + CNT_ONE;
						if (cnt_reg + CNT_ONE == len_bits)
						begin
							state_next = ST_FINISH;
						end
					end
				end
			end
			ST_FINISH:
			begin
				ev.done    = 1'b1;
				mck_next   = 1'b0;
				state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ============================================================
	// Registers and status
	always_comb
	begin
		ctrl_next         = ctrl_reg;
		baud_divisor_next = baud_divisor_reg;
		mask_next         = mask_reg;
		status_next       = status_reg;
		rx_full_next      = rx_full_reg;
		if (rd_acc && paddr == OFS_DATA)
		begin
			rx_full_next = 1'b0;
		end
		if (ev.done)
		begin
			rx_full_next = 1'b1;
		end
		if (wr_acc)
		begin
			if (paddr == OFS_CTRL)
			begin
				ctrl_next.enable            = pwdata[CTRL_EN_BIT];
				ctrl_next.master            = pwdata[CTRL_MASTER_BIT];
				ctrl_next.char_length_field = pwdata[CTRL_LEN_LSB +: LEN_W];
			end
			else if (paddr == OFS_STATUS)
			begin
				status_next.done      = status_reg.done & ~pwdata[ST_DONE_BIT];
				status_next.collision = status_reg.collision & ~pwdata[ST_COLL_BIT];
			end
			else if (paddr == OFS_MASK)
			begin
				mask_next.done      = pwdata[ST_DONE_BIT];
				mask_next.collision = pwdata[ST_COLL_BIT];
			end
			else if (paddr == OFS_BAUD_HI)
			begin
				baud_divisor_next[BAUD_W-1:BYTE_HI_LSB] = pwdata[DATA_W-1:0];
			end
			else if (paddr == OFS_BAUD_LO)
			begin
				baud_divisor_next[BYTE_HI_LSB-1:0] = pwdata[DATA_W-1:0];
			end
		end
		// Set beats a simultaneous clear
		status_next = status_next | ev;
		irq_next    = |(status_next & mask_next);
	end

	// ============================================================
	// APB answer: registered, ready in the first access cycle
	always_comb
	begin
		prdata_next  = '0;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (setup)
		begin
			pready_next = 1'b1;
			if (paddr == OFS_DATA)
			begin
				prdata_next[DATA_W-1:0] = serial_shift_data_reg;
			end
			else if (paddr == OFS_CTRL)
			begin
				prdata_next[CTRL_EN_BIT]              = ctrl_reg.enable;
				prdata_next[CTRL_MASTER_BIT]          = ctrl_reg.master;
				prdata_next[CTRL_LEN_LSB +: LEN_W]    = ctrl_reg.char_length_field;
			end
			else if (paddr == OFS_STATUS)
			begin
				prdata_next[ST_BUSY_BIT]   = busy;
				prdata_next[ST_DONE_BIT]   = status_reg.done;
				prdata_next[ST_COLL_BIT]   = status_reg.collision;
				prdata_next[ST_RXFULL_BIT] = rx_full_reg;
			end
			else if (paddr == OFS_MASK)
			begin
				prdata_next[ST_DONE_BIT] = mask_reg.done;
				prdata_next[ST_COLL_BIT] = mask_reg.collision;
			end
			else if (paddr == OFS_BAUD_HI)
			begin
				prdata_next[DATA_W-1:0] = baud_divisor_reg[BAUD_W-1:BYTE_HI_LSB];
			end
			else if (paddr == OFS_BAUD_LO)
			begin
				prdata_next[DATA_W-1:0] = baud_divisor_reg[BYTE_HI_LSB-1:0];
			end
			else
			begin
				pslverr_next = 1'b1;
			end
		end
		else if (psel && penable && !pready_reg)
		begin
			pready_next = 1'b1;
		end
	end

	// ============================================================
	// Pin drivers
	always_comb
	begin
		pins_next         = '0;
		pins_next.ss_n    = 1'b1;
		pins_next.sck     = mck_next;
		pins_next.mosi    = serial_shift_data_next[DATA_W-1];
		pins_next.miso    = serial_shift_data_next[DATA_W-1];
		if (ctrl_next.enable)
		begin
			pins_next.sck_oe  = ctrl_next.master;
			pins_next.mosi_oe = ctrl_next.master;
			pins_next.ss_n_oe = ctrl_next.master;
			pins_next.ss_n    = ~(ctrl_next.master && state_next != ST_IDLE);
			pins_next.miso_oe = ~ctrl_next.master & ~pin_s.ss_n;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ctrl_reg              <= CTRL_RESET;
			baud_divisor_reg      <= {BAUD_HI_RST, BAUD_LO_RST};
			serial_shift_data_reg <= DATA_RESET;
			state_reg             <= ST_IDLE;
			cnt_reg               <= CNT_ZERO;
			sample_reg            <= 1'b0;
			mck_reg               <= 1'b0;
			sck_prev_reg          <= 1'b0;
			rx_full_reg           <= 1'b0;
			status_reg            <= '0;
			mask_reg              <= '0;
			pins_reg              <= '{ss_n: 1'b1, default: 1'b0};
			irq_reg               <= 1'b0;
			prdata_reg            <= '0;
			pready_reg            <= 1'b0;
			pslverr_reg           <= 1'b0;
		end
		else
		begin
			ctrl_reg              <= ctrl_next;
			baud_divisor_reg      <= baud_divisor_next;
			serial_shift_data_reg <= serial_shift_data_next;
			state_reg             <= state_next;
			cnt_reg               <= cnt_next;
			sample_reg            <= sample_next;
			mck_reg               <= mck_next;
			sck_prev_reg          <= pin_s.sck;
			rx_full_reg           <= rx_full_next;
			status_reg            <= status_next;
			mask_reg              <= mask_next;
			pins_reg              <= pins_next;
			irq_reg               <= irq_next;
			prdata_reg            <= prdata_next;
			pready_reg            <= pready_next;
			pslverr_reg           <= pslverr_next;
		end
	end

	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign pins_out = pins_reg;
	assign irq      = irq_reg;

	// ============================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence seq_busy_write;
		wr_data && busy && !fall_ev;
	endsequence

	sequence seq_idle_slave_write;
		wr_ok && !ctrl_reg.master;
	endsequence

	chk_disabled_hiz: assert property (
		!ctrl_next.enable |=> !pins_out.mosi_oe && !pins_out.miso_oe)
		else $error("data line driven while disabled");
	chk_master_dirs: assert property (
		ctrl_next.enable && ctrl_next.master |=> pins_out.mosi_oe && !pins_out.miso_oe)
		else $error("master pin directions wrong");
	chk_miso_release: assert property (pin_s.ss_n |=> !pins_out.miso_oe)
		else $error("slave drives data while deselected");
	chk_overrun_flag: assert property (seq_busy_write |=> status_reg.collision)
		else $error("collision flag not set");
	chk_write_dropped: assert property (
		seq_busy_write |=> serial_shift_data_reg == $past(serial_shift_data_reg))
		else $error("shift register changed by busy write");
	chk_master_start: assert property (
		wr_ok && ctrl_reg.master && ctrl_reg.enable |=> state_reg == ST_SHIFT ##1 !pins_out.ss_n)
		else $error("master write did not start");
	chk_slave_load: assert property (
		seq_idle_slave_write |=> state_reg == ST_IDLE &&
		serial_shift_data_reg == $past(pwdata[DATA_W-1:0]))
		else $error("slave write not a plain load");
	chk_slave_ignore: assert property (
		!ctrl_reg.master && !slave_sel && state_reg == ST_IDLE && !wr_ok |=> state_reg == ST_IDLE)
		else $error("slave moved while deselected");
	chk_msb_shift: assert property (
		fall_ev && state_reg == ST_SHIFT |=>
		serial_shift_data_reg == {$past(serial_shift_data_reg[DATA_W-2:0]), $past(sample_reg)})
		else $error("shift not msb first");
	chk_read_now: assert property (
		setup && paddr == OFS_DATA && !pwrite |=>
		prdata[DATA_W-1:0] == $past(serial_shift_data_reg) && pready)
		else $error("data read mismatch");

endmodule

//--- test/spi_far_end.sv
// Behavioural far-side serial device: slave when the port is master, master otherwise.
// Assumes resolved pin levels from the bench and mode 0 timing on the serial clock.
`timescale 1ns/1ps
module spi_far_end
	import spi_shift_pkg::*;
(
	input  wire logic clock,
	input  wire logic far_master,
	input  wire logic sck_w,
	input  wire logic mosi_w,
	input  wire logic miso_w,
	input  wire logic ss_n_w,
	output logic      p_sck,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss_n
);
	logic [7:0] sh;
	logic       rx_bit;
	logic       in_frame;
	int         bits;

	initial
	begin
		p_sck = 1'b0;
		p_mosi = 1'b0;
		p_miso = 1'b0;
		p_ss_n = 1'b1;
		sh = 8'h00;
		rx_bit = 1'b0;
		in_frame = 1'b0;
		bits = 0;
	end

	// ============================================================
	// Slave side
	always @(posedge sck_w)
		if (!far_master && !ss_n_w)
			rx_bit = mosi_w;
	always @(negedge sck_w)
		if (!far_master && !ss_n_w)
		begin
			sh = {sh[6:0], rx_bit};
			bits++;
		end
	// Released line toggles so a stale level never passes for data
	always @(posedge clock)
		p_miso <= (!far_master && !ss_n_w) ? sh[7] : ~p_miso;
	always @(posedge clock)
		if (!in_frame)
			p_mosi <= ~p_mosi;

	task automatic prime(input logic [7:0] b);
		sh = b;
		bits = 0;
	endtask

	// ============================================================
	// Master side
	task automatic frame(input logic [7:0] b, input int n, input int half);
		int i;
		in_frame = 1'b1;
		sh = b;
		bits = 0;
		@(posedge clock);
		p_ss_n <= 1'b0;
		p_mosi <= sh[7];
		repeat (half + 2) @(posedge clock);
		for (i = 0; i < n; i++)
		begin
			p_sck <= 1'b1;
			rx_bit = miso_w;
			repeat (half) @(posedge clock);
			p_sck <= 1'b0;
			sh = {sh[6:0], rx_bit};
			bits++;
			p_mosi <= sh[7];
			repeat (half) @(posedge clock);
		end
		p_ss_n <= 1'b1;
		in_frame = 1'b0;
	endtask

	// Clock pulses while deselected
	task automatic stray(input int n, input int half);
		repeat (n)
		begin
			@(posedge clock);
			p_sck <= 1'b1;
			repeat (half) @(posedge clock);
			p_sck <= 1'b0;
		end
	endtask
endmodule

//--- test/tb.sv
// Self-checking bench of the serial shift port over APB with a far-side model.
// Assumes the package register map and a 10 MHz system clock.
`timescale 1ns/1ps
module tb
	import spi_shift_pkg::*;
;
	logic              clock = 1'b0;
	logic              sys_rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	pins_in_t          pins_in;
	pins_out_t         pins_out;
	logic              far_master;
	logic              p_sck;
	logic              p_mosi;
	logic              p_miso;
	logic              p_ss_n;
	logic [31:0]       rd;
	logic              er;
	int                mismatches;
	int                checks;

	always #50 clock = ~clock;

	// ============================================================
	// Pin resolution
	wire logic sck_w  = pins_out.sck_oe ? pins_out.sck : p_sck;
	wire logic mosi_w = pins_out.mosi_oe ? pins_out.mosi : p_mosi;
	wire logic miso_w = pins_out.miso_oe ? pins_out.miso : p_miso;
	wire logic ss_n_w = pins_out.ss_n_oe ? pins_out.ss_n : p_ss_n;
	assign pins_in = '{sck: sck_w, mosi: mosi_w, miso: miso_w, ss_n: ss_n_w};

	spi_shift_port dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

	spi_far_end far (.clock(clock), .far_master(far_master), .sck_w(sck_w), .mosi_w(mosi_w),
		.miso_w(miso_w), .ss_n_w(ss_n_w), .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso),
		.p_ss_n(p_ss_n));

	// ============================================================
	// Shared tasks
	task automatic finish_test;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			check("pready timeout", 32'(pready), 32'h1);
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask

	task automatic settle_irq(input string what, input logic exp);
		repeat (3) @(posedge clock);
		check(what, 32'(irq), 32'(exp));
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 600)
		begin
			@(posedge clock);
			n++;
		end
		if (irq !== 1'b1)
		begin
			check("irq timeout", 32'(irq), 32'h1);
			finish_test();
		end
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset;
		rdc("data reset", OFS_DATA, 32'(DATA_RESET));
		rdc("ctrl reset", OFS_CTRL, 32'h0);
		rdc("status reset", OFS_STATUS, 32'h0);
		rdc("divisor high reset", OFS_BAUD_HI, 32'(BAUD_HI_RST));
		rdc("divisor low reset", OFS_BAUD_LO, 32'(BAUD_LO_RST));
		apb(1'b0, 12'hF78, 32'h0);
		check("unmapped error", 32'(er), 32'h1);
		check("unmapped data", rd, 32'h0);
		check("disabled data oe", 32'({pins_out.mosi_oe, pins_out.miso_oe}), 32'h0);
		apb(1'b1, OFS_BAUD_LO, 32'h4);
		apb(1'b1, OFS_BAUD_HI, 32'h0);
		rdc("divisor low", OFS_BAUD_LO, 32'h4);
		rdc("divisor high", OFS_BAUD_HI, 32'h0);
		check("mapped error", 32'(er), 32'h0);
	endtask

	task automatic t_master;
		apb(1'b1, OFS_CTRL, 32'h3);
		apb(1'b1, OFS_MASK, 32'h6);
		far.prime(8'h3C);
		apb(1'b1, OFS_DATA, 32'hA5);
		// Second write lands mid-transfer and must be dropped
		apb(1'b1, OFS_DATA, 32'h11);
		check("master pins", 32'({pins_out.sck_oe, pins_out.mosi_oe, pins_out.miso_oe,
			pins_out.ss_n}), 32'hC);
		rdc("busy and collision", OFS_STATUS, 32'h5);
		check("collision irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_STATUS, 32'h4);
		settle_irq("collision cleared", 1'b0);
		wait_irq();
		check("far received", 32'(far.sh), 32'hA5);
		check("bit count", 32'(far.bits), 32'h8);
		rdc("master receive", OFS_DATA, 32'h3C);
		rdc("done only", OFS_STATUS, 32'h2);
		apb(1'b1, OFS_MASK, 32'h0);
		settle_irq("masked", 1'b0);
		apb(1'b1, OFS_MASK, 32'h6);
		settle_irq("unmasked", 1'b1);
		apb(1'b1, OFS_STATUS, 32'h2);
		settle_irq("done cleared", 1'b0);
	endtask

	task automatic t_short;
		apb(1'b1, OFS_CTRL, 32'h13);
		far.prime(8'h96);
		apb(1'b1, OFS_DATA, 32'hA0);
		wait_irq();
		check("far nibble", 32'(far.sh[3:0]), 32'hA);
		check("short bit count", 32'(far.bits), 32'h4);
		// Unread character still held, so this write must bounce
		apb(1'b1, OFS_DATA, 32'h77);
		apb(1'b0, OFS_DATA, 32'h0);
		check("short receive", 32'(rd[3:0]), 32'h9);
		rdc("refused while full", OFS_STATUS, 32'h6);
		apb(1'b1, OFS_STATUS, 32'h6);
	endtask

	task automatic t_slave;
		@(posedge clock);
		far_master <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, OFS_DATA, 32'h5A);
		repeat (4) @(posedge clock);
		check("slave idle pins", 32'({pins_out.sck_oe, pins_out.mosi_oe,
			pins_out.miso_oe}), 32'h0);
		far.stray(3, 5);
		rdc("slave loaded", OFS_DATA, 32'h5A);
		rdc("slave no start", OFS_STATUS, 32'h0);
		fork
			far.frame(8'hC3, 8, 5);
			begin
				repeat (12) @(posedge clock);
				check("slave drive", 32'({pins_out.mosi_oe, pins_out.miso_oe}), 32'h1);
			end
		join
		wait_irq();
		check("far master got", 32'(far.sh), 32'h5A);
		rdc("slave receive", OFS_DATA, 32'hC3);
		apb(1'b1, OFS_STATUS, 32'h2);
		// Deselect after three bits: no done, partial character kept
		far.frame(8'hFF, 3, 5);
		repeat (8) @(posedge clock);
		rdc("aborted frame", OFS_STATUS, 32'h0);
		rdc("partial kept", OFS_DATA, 32'h1F);
	endtask

	task automatic t_disable;
		apb(1'b1, OFS_CTRL, 32'h2);
		repeat (4) @(posedge clock);
		check("disabled master oe", 32'({pins_out.mosi_oe, pins_out.miso_oe}), 32'h0);
	endtask

	// ============================================================
	// Main sequence
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		far_master = 1'b0;
		mismatches = 0;
		checks = 0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_master();
		t_short();
		t_slave();
		t_disable();
		finish_test();
	end
endmodule
